// File: design/cctc_pkg.sv
/*
 * constants for the capture/compare timer core: register indices, field
 * positions, reset values and option codes.
 * assumes a register port with a 4-bit word index and 16-bit data.
 */
package cctc_pkg;
	// register indices on the register port
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_MODE = 4'h1;
	localparam logic [3:0] A_IOC0 = 4'h2;
	localparam logic [3:0] A_IOC1 = 4'h3;
	localparam logic [3:0] A_IEN = 4'h4;
	localparam logic [3:0] A_STAT = 4'h5;
	localparam logic [3:0] A_CNT = 4'h6;
	localparam logic [3:0] A_GRA = 4'h7;
	localparam logic [3:0] A_GRB = 4'h8;
	localparam logic [3:0] A_GRC = 4'h9;
	localparam logic [3:0] A_GRD = 4'ha;
	// reset values and counter limits
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] GR_RESET = 16'hffff;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	// field positions
	localparam int CTRL_CLR_BIT = 3;
	localparam int WRAP_BIT = 4;
	localparam int IOC_STRIDE = 4;
	localparam int IOC_CAP_BIT = 2;
	// count source codes
	localparam logic [2:0] CKS_STOP = 3'h0;
	localparam logic [2:0] CKS_DIV1 = 3'h1;
	localparam logic [2:0] CKS_DIV2 = 3'h2;
	localparam logic [2:0] CKS_DIV4 = 3'h3;
	localparam logic [2:0] CKS_DIV8 = 3'h4;
	localparam logic [2:0] CKS_EXT = 3'h5;
	// compare output actions
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// capture edge selection
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
endpackage : cctc_pkg

// File: design/cctc_edge_det.sv
/*
 * edge detector for one synchronous input: rising, falling or both.
 * assumes the input is already synchronous to clk_in.
 */
module cctc_edge_det
(
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	// level and selection
	input wire logic level_in,
	input wire logic [1:0] sel_in,
	// one-cycle detection pulse
	output logic hit_out
);
	typedef struct packed {
		logic primed;
		logic prev;
		logic hit;
	} cctc_edge_state_t;

	cctc_edge_state_t s_r;
	cctc_edge_state_t s_nxt;
	logic rise;
	logic fall;

	// no edge in the first cycle after reset: the old level is unknown
	assign rise = s_r.primed && !s_r.prev && level_in;
	assign fall = s_r.primed && s_r.prev && !level_in;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.primed = 1'b1;
		s_nxt.prev = level_in;
		if (sel_in == cctc_pkg::EDGE_RISE)
			s_nxt.hit = rise;
		else if (sel_in == cctc_pkg::EDGE_FALL)
			s_nxt.hit = fall;
		else
			s_nxt.hit = rise || fall;
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
			s_r <= '0;
		else if (clk_en_in)
			s_r <= s_nxt;
	end

	assign hit_out = s_r.hit;

	// one sample per level is enough because levels last two cycles
	edge_pulse_a: assert property (@(posedge clk_in) disable iff (reset_in)
		clk_en_in && rise && sel_in == cctc_pkg::EDGE_RISE |=> hit_out)
		else $error("rising edge not reported");
endmodule : cctc_edge_det

// File: design/cctc_timer.sv
/*
 * 16-bit capture/compare timer with four general registers.
 * assumes a one-cycle register port and inputs synchronous to clk_in.
 */
// Summary of operation
// - counter is a 16-bit up-counter, readable and writable
// - three-bit count source field picks the increment source
// - with clear enabled, compare match A resets counter to zero
// - counter wrap from all ones to zero sets the wrap flag
// - wrap raises interrupt only when its enable bit is set
// - reset loads counter with zero
// - each general register is compare or capture, per io control
// - compare mode: equality sets match flag, interrupt if enabled
// - each compare match drives a selectable output action
// - capture edge stores counter in general register, sets flag
// - capture raises interrupt only when its enable bit is set
// - buffer enables make C and D buffers for A and B
// - buffered compare: match copies buffer into its register
// - buffered capture: counter into register, old value to buffer
// - reset sets all general registers to all ones
// - capture on rising, falling or both edges per channel
// - clearing on match A with value N gives period N plus one
module cctc_timer
(
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	// register port
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rd_data_out,
	// pins
	input wire logic [3:0] capture_in,
	input wire logic ext_count_in,
	output logic [3:0] compare_out,
	output logic irq_out
);
	typedef struct packed {
		logic [15:0] cnt;
		logic [3:0][15:0] gr;
		logic [2:0] cks;
		logic clr_en;
		logic [1:0] buf_en;
		logic [3:0][2:0] ioc;
		logic [3:0] match_ie;
		logic wrap_ie;
		logic [3:0] match_flag;
		logic wrap_flag;
		logic [2:0] pre;
		logic [3:0] pin;
		logic irq;
		logic [15:0] rdata;
	} cctc_state_t;

	cctc_state_t s_r;
	cctc_state_t s_nxt;
	logic [4:0] hit_w;
	logic [3:0] match_w;
	logic [3:0] capture_w;
	logic [3:0] own_w;
	logic tick;
	logic sw_cnt_wr;

	function automatic logic is_capture(input logic [2:0] ioc);
		is_capture = ioc[cctc_pkg::IOC_CAP_BIT];
	endfunction : is_capture

	function automatic logic count_tick(input logic [2:0] cks, input logic [2:0] pre,
		input logic ext);
		case (cks)
			cctc_pkg::CKS_DIV1: count_tick = 1'b1;
			cctc_pkg::CKS_DIV2: count_tick = pre[0];
			cctc_pkg::CKS_DIV4: count_tick = &pre[1:0];
			cctc_pkg::CKS_DIV8: count_tick = &pre;
			cctc_pkg::CKS_EXT: count_tick = ext;
			default: count_tick = 1'b0;
		endcase
	endfunction : count_tick

	// prescaler runs freely so a source change takes effect at once
	assign tick = count_tick(s_r.cks, s_r.pre, hit_w[4]);
	assign sw_cnt_wr = wr_in && addr_in == cctc_pkg::A_CNT;

	genvar g;
	generate
		for (g = 0; g < 5; g++)
		begin : g_edge
			logic [1:0] sel;
			logic lvl;
			if (g < 4)
			begin : g_cap
				assign sel = s_r.ioc[g][1:0];
				assign lvl = capture_in[g];
			end
			else
			begin : g_ext
				assign sel = cctc_pkg::EDGE_RISE;
				assign lvl = ext_count_in;
			end
			cctc_edge_det u_edge
			(
				.clk_in(clk_in),
				.reset_in(reset_in),
				.clk_en_in(clk_en_in),
				.level_in(lvl),
				.sel_in(sel),
				.hit_out(hit_w[g])
			);
		end
		for (g = 0; g < 4; g++)
		begin : g_chan
			// a buffering register gives up its own compare and capture
			if (g < 2)
			begin : g_main
				assign own_w[g] = 1'b1;
			end
			else
			begin : g_buf
				assign own_w[g] = !s_r.buf_en[g - 2];
			end
			// match counts once per count step, not while stopped
			assign match_w[g] = own_w[g] && !is_capture(s_r.ioc[g]) && tick
				&& s_r.cnt == s_r.gr[g];
			assign capture_w[g] = own_w[g] && is_capture(s_r.ioc[g]) && hit_w[g];
		end
	endgenerate

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pre = s_r.pre + 3'h1;
		s_nxt.rdata = '0;
		// counter
		if (tick)
		begin
			if (s_r.clr_en && match_w[0])
				s_nxt.cnt = cctc_pkg::CNT_RESET;
			else
				s_nxt.cnt = s_r.cnt + cctc_pkg::CNT_ONE;
			if (s_r.cnt == cctc_pkg::CNT_MAX)
				s_nxt.wrap_flag = 1'b1;
		end
		// clearing: a 0 written to a status bit clears it
		if (wr_in && addr_in == cctc_pkg::A_STAT)
		begin
			s_nxt.match_flag = s_r.match_flag & wr_data_in[3:0];
			s_nxt.wrap_flag = (s_r.wrap_flag && wr_data_in[cctc_pkg::WRAP_BIT])
				|| (tick && s_r.cnt == cctc_pkg::CNT_MAX);
		end
		// channel events; set wins over a clear in the same cycle
		for (int i = 0; i < 4; i++)
		begin
			if (match_w[i])
			begin
				s_nxt.match_flag[i] = 1'b1;
				case (s_r.ioc[i][1:0])
					cctc_pkg::ACT_LOW: s_nxt.pin[i] = 1'b0;
					cctc_pkg::ACT_HIGH: s_nxt.pin[i] = 1'b1;
					cctc_pkg::ACT_TOGGLE: s_nxt.pin[i] = !s_r.pin[i];
					default: s_nxt.pin[i] = s_r.pin[i];
				endcase
			end
			if (capture_w[i])
			begin
				s_nxt.gr[i] = s_r.cnt;
				s_nxt.match_flag[i] = 1'b1;
			end
		end
		// buffer moves for A/C and B/D
		for (int j = 0; j < 2; j++)
		begin
			if (s_r.buf_en[j] && match_w[j])
				s_nxt.gr[j] = s_r.gr[j + 2];
			if (s_r.buf_en[j] && capture_w[j])
				s_nxt.gr[j + 2] = s_r.gr[j];
		end
		// software writes win over hardware updates of the same register
		if (wr_in)
		begin
			case (addr_in)
				cctc_pkg::A_CTRL:
				begin
					s_nxt.cks = wr_data_in[2:0];
					s_nxt.clr_en = wr_data_in[cctc_pkg::CTRL_CLR_BIT];
				end
				cctc_pkg::A_MODE: s_nxt.buf_en = wr_data_in[1:0];
				cctc_pkg::A_IOC0:
				begin
					s_nxt.ioc[0] = wr_data_in[2:0];
					s_nxt.ioc[1] = wr_data_in[cctc_pkg::IOC_STRIDE +: 3];
				end
				cctc_pkg::A_IOC1:
				begin
					s_nxt.ioc[2] = wr_data_in[2:0];
					s_nxt.ioc[3] = wr_data_in[cctc_pkg::IOC_STRIDE +: 3];
				end
				cctc_pkg::A_IEN:
				begin
					s_nxt.match_ie = wr_data_in[3:0];
					s_nxt.wrap_ie = wr_data_in[cctc_pkg::WRAP_BIT];
				end
				cctc_pkg::A_CNT: s_nxt.cnt = wr_data_in;
				default:
				begin
					if (addr_in >= cctc_pkg::A_GRA && addr_in <= cctc_pkg::A_GRD)
						s_nxt.gr[2'(addr_in - cctc_pkg::A_GRA)] = wr_data_in;
				end
			endcase
		end
		// read data stand in the following cycle only
		if (rd_in)
		begin
			case (addr_in)
				cctc_pkg::A_CTRL: s_nxt.rdata = {12'h000, s_r.clr_en, s_r.cks};
				cctc_pkg::A_MODE: s_nxt.rdata = {14'h0000, s_r.buf_en};
				cctc_pkg::A_IOC0: s_nxt.rdata = {9'h000, s_r.ioc[1], 1'b0, s_r.ioc[0]};
				cctc_pkg::A_IOC1: s_nxt.rdata = {9'h000, s_r.ioc[3], 1'b0, s_r.ioc[2]};
				cctc_pkg::A_IEN: s_nxt.rdata = {11'h000, s_r.wrap_ie, s_r.match_ie};
				cctc_pkg::A_STAT: s_nxt.rdata = {11'h000, s_r.wrap_flag, s_r.match_flag};
				cctc_pkg::A_CNT: s_nxt.rdata = s_r.cnt;
				default:
				begin
					if (addr_in >= cctc_pkg::A_GRA && addr_in <= cctc_pkg::A_GRD)
						s_nxt.rdata = s_r.gr[2'(addr_in - cctc_pkg::A_GRA)];
				end
			endcase
		end
		// level request while any enabled flag is set
		s_nxt.irq = |(s_nxt.match_flag & s_nxt.match_ie)
			|| (s_nxt.wrap_flag && s_nxt.wrap_ie);
	end

	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			s_r <= '0;
			s_r.cnt <= cctc_pkg::CNT_RESET;
			s_r.gr <= {4{cctc_pkg::GR_RESET}};
		end
		else if (clk_en_in)
			s_r <= s_nxt;
	end

	assign rd_data_out = s_r.rdata;
	assign compare_out = s_r.pin;
	assign irq_out = s_r.irq;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	count_step_a: assert property (clk_en_in && tick && !match_w[0] && !sw_cnt_wr
		|=> s_r.cnt == 16'($past(s_r.cnt) + cctc_pkg::CNT_ONE))
		else $error("counter did not step by one");
	match_clear_a: assert property (clk_en_in && tick && s_r.clr_en && match_w[0] && !sw_cnt_wr
		|=> s_r.cnt == cctc_pkg::CNT_RESET)
		else $error("counter not cleared on match A");
	wrap_flag_a: assert property (clk_en_in && tick && s_r.cnt == cctc_pkg::CNT_MAX
		|=> s_r.wrap_flag)
		else $error("wrap flag not set");
	reset_load_a: assert property (@(posedge clk_in) disable iff (1'b0) reset_in
		|=> s_r.cnt == cctc_pkg::CNT_RESET && s_r.gr == {4{cctc_pkg::GR_RESET}})
		else $error("reset values wrong");
	wrap_irq_a: assert property (s_r.wrap_flag && s_r.wrap_ie |-> irq_out)
		else $error("wrap request missing");
	compare_flag_a: assert property (clk_en_in && match_w[1]
		|=> s_r.match_flag[1] && (irq_out || !s_r.match_ie[1]))
		else $error("compare flag or request missing");
	capture_store_a: assert property (clk_en_in && capture_w[1] && !(wr_in && addr_in == cctc_pkg::A_GRB)
		|=> s_r.gr[1] == $past(s_r.cnt) && s_r.match_flag[1])
		else $error("capture did not store counter");
	buffer_cmp_a: assert property (clk_en_in && s_r.buf_en[0] && match_w[0] && !(wr_in && addr_in == cctc_pkg::A_GRA)
		|=> s_r.gr[0] == $past(s_r.gr[2]))
		else $error("buffer not copied on match");
	buffer_cap_a: assert property (clk_en_in && s_r.buf_en[0] && capture_w[0] && !wr_in
		|=> s_r.gr[2] == $past(s_r.gr[0]) && s_r.gr[0] == $past(s_r.cnt))
		else $error("buffered capture wrong");
	flag_hold_a: assert property (s_r.match_flag[0] && !(clk_en_in && wr_in && addr_in == cctc_pkg::A_STAT)
		|=> s_r.match_flag[0])
		else $error("flag dropped without clear");
	pin_high_a: assert property (clk_en_in && match_w[3] && s_r.ioc[3][1:0] == cctc_pkg::ACT_HIGH
		|=> compare_out[3])
		else $error("compare output not driven high");
	hold_still_a: assert property (!clk_en_in
		|=> $stable(s_r))
		else $error("state moved while frozen");
	idle_count_a: assert property (clk_en_in && !tick && !sw_cnt_wr
		|=> s_r.cnt == $past(s_r.cnt))
		else $error("counter moved without a count step");
	cnt_write_a: assert property (clk_en_in && sw_cnt_wr
		|=> s_r.cnt == $past(wr_data_in))
		else $error("counter write lost");
	gr_write_a: assert property (clk_en_in && wr_in && addr_in == cctc_pkg::A_GRD
		|=> s_r.gr[3] == $past(wr_data_in))
		else $error("general register write lost");
	read_idle_a: assert property (clk_en_in && !rd_in
		|=> rd_data_out == 16'h0000)
		else $error("read data outside read cycle");
	read_count_a: assert property (clk_en_in && rd_in && addr_in == cctc_pkg::A_CNT
		|=> rd_data_out == $past(s_r.cnt))
		else $error("counter read wrong");
	read_status_a: assert property (clk_en_in && rd_in && addr_in == cctc_pkg::A_STAT
		|=> rd_data_out == 16'({$past(s_r.wrap_flag), $past(s_r.match_flag)}))
		else $error("status read wrong");
	irq_on_a: assert property (|(s_r.match_flag & s_r.match_ie)
		|-> irq_out)
		else $error("match request missing");
	irq_off_a: assert property (!(|(s_r.match_flag & s_r.match_ie)) && !(s_r.wrap_flag && s_r.wrap_ie)
		|-> !irq_out)
		else $error("request without enabled flag");
	wrap_quiet_a: assert property (clk_en_in && !s_r.wrap_flag && !(tick && s_r.cnt == cctc_pkg::CNT_MAX)
		|=> !s_r.wrap_flag)
		else $error("wrap flag set without wrap");
	wrap_clear_a: assert property (clk_en_in && wr_in && addr_in == cctc_pkg::A_STAT
		&& !wr_data_in[cctc_pkg::WRAP_BIT] && !(tick && s_r.cnt == cctc_pkg::CNT_MAX)
		|=> !s_r.wrap_flag)
		else $error("wrap flag not cleared");
	pin_toggle_a: assert property (clk_en_in && match_w[0] && s_r.ioc[0][1:0] == cctc_pkg::ACT_TOGGLE
		|=> compare_out[0] != $past(compare_out[0]))
		else $error("compare output did not toggle");
	compare_keep_a: assert property (clk_en_in && !is_capture(s_r.ioc[1]) && !match_w[1]
		&& !(wr_in && addr_in == cctc_pkg::A_GRB) |=> s_r.gr[1] == $past(s_r.gr[1]))
		else $error("compare register changed");
	buffer_own_a: assert property (s_r.buf_en[0]
		|-> !match_w[2] && !capture_w[2])
		else $error("buffer register acted alone");
	match_set_a: assert property (clk_en_in && match_w[0]
		|=> s_r.match_flag[0])
		else $error("match flag a not set");
	capture_irq_a: assert property (clk_en_in && capture_w[1] && s_r.match_ie[1] && !wr_in
		|=> irq_out)
		else $error("capture request missing");

	clear_cycle_c: cover property (match_w[0] && s_r.clr_en ##1 s_r.cnt == cctc_pkg::CNT_RESET);
	buffered_cap_c: cover property (capture_w[0] && s_r.buf_en[0]);
	wrap_c: cover property (tick && s_r.cnt == cctc_pkg::CNT_MAX);
	freeze_c: cover property (!clk_en_in ##1 clk_en_in);
	buffered_cmp_c: cover property (match_w[0] && s_r.buf_en[0]);
endmodule : cctc_timer

// File: test/cctc_pin_model.sv
/*
 * pin-side model: drives capture pins and the external count source,
 * and times the spacing of compare pin a changes.
 * assumes one clock shared with the timer; the bench calls its tasks.
 */
module cctc_pin_model
(
	// clock
	input wire logic clk_in,
	// timer pins
	input wire logic [3:0] compare_in,
	output logic [3:0] capture_out,
	output logic ext_count_out,
	// cycles between the last two changes of compare pin a
	output logic [15:0] period_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] last_cmp_r = 4'h0;
	logic [15:0] run_r = 16'h0001;
	initial
	begin
		capture_out = 4'h0;
		ext_count_out = 1'b0;
		period_out = 16'h0000;
	end
	always @(posedge clk_in)
	begin
		last_cmp_r <= compare_in;
		if (last_cmp_r[0] !== compare_in[0])
		begin
			period_out <= run_r;
			run_r <= 16'h0001;
		end
		else
			run_r <= run_r + 16'h0001;
	end
	// a shorter level could slip past the edge detector
	task automatic set_level(input int ch, input logic lvl);
		@(posedge clk_in);
		capture_out[ch] <= lvl;
		repeat (2) @(posedge clk_in);
	endtask : set_level
	task automatic ext_pulses(input int n);
		repeat (n)
		begin
			@(posedge clk_in);
			ext_count_out <= 1'b1;
			repeat (2) @(posedge clk_in);
			ext_count_out <= 1'b0;
			@(posedge clk_in);
		end
	endtask : ext_pulses
endmodule : cctc_pin_model

// File: test/cctc_tb.sv
/*
 * self-checking bench for the capture/compare timer core.
 * assumes the design package and the pin model.
 */
`define check_eq(nm, exp, got) \
	begin \
		check_count++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("BAD %s expected %h seen %h", nm, exp, got); \
		end \
	end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic wr; logic [3:0] addr; logic [15:0] data; logic [15:0] exp;} cctc_row_t;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic clk_en_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [15:0] wr_data_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [15:0] rd_data_out;
	logic [3:0] capture;
	logic ext_count;
	logic [3:0] compare_out;
	logic irq_out;
	logic [15:0] period;
	logic [15:0] exp_b;
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;
	cctc_row_t rows [9] = '{
		'{1'b0, cctc_pkg::A_CNT, 16'h0000, cctc_pkg::CNT_RESET},
		'{1'b0, cctc_pkg::A_GRA, 16'h0000, cctc_pkg::GR_RESET},
		'{1'b0, 4'h8, 16'h0000, cctc_pkg::GR_RESET},
		'{1'b0, 4'h9, 16'h0000, cctc_pkg::GR_RESET},
		'{1'b0, cctc_pkg::A_GRD, 16'h0000, cctc_pkg::GR_RESET},
		'{1'b1, cctc_pkg::A_CNT, 16'habcd, 16'habcd},
		'{1'b1, 4'h8, 16'h1234, 16'h1234},
		'{1'b1, cctc_pkg::A_GRD, 16'h0f0f, 16'h0f0f},
		'{1'b1, 4'hf, 16'h5a5a, 16'h0000}};
	always #50 clk_in = ~clk_in;
	cctc_timer cctc_timer_inst
	(
		.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.capture_in(capture), .ext_count_in(ext_count), .compare_out(compare_out), .irq_out(irq_out)
	);
	cctc_pin_model cctc_pin_model_inst
	(
		.clk_in(clk_in), .compare_in(compare_out), .capture_out(capture),
		.ext_count_out(ext_count), .period_out(period)
	);
	task automatic results;
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		`check_eq("read data", exp, rd_data_out)
	endtask : rd_reg
	// the hang limit sits well above the few hundred cycles used
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			bad_count++;
			results();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		@(negedge clk_in);
		`check_eq("compare pins", 4'h0, compare_out)
		`check_eq("irq", 1'b0, irq_out)
		foreach (rows[i])
		begin
			if (rows[i].wr)
				wr_reg(rows[i].addr, rows[i].data);
			rd_reg(rows[i].addr, rows[i].exp);
		end
		wr_reg(cctc_pkg::A_CNT, 16'h0000);
		wr_reg(cctc_pkg::A_GRA, 16'h0004);
		wr_reg(cctc_pkg::A_IOC0, {14'h0000, cctc_pkg::ACT_TOGGLE});
		wr_reg(cctc_pkg::A_IEN, 16'h0001);
		wr_reg(cctc_pkg::A_CTRL, 16'h0009);
		repeat (30) @(negedge clk_in);
		`check_eq("match period", 16'h0005, period)
		`check_eq("match irq", 1'b1, irq_out)
		wr_reg(cctc_pkg::A_CTRL, 16'h0000);
		rd_reg(cctc_pkg::A_STAT, 16'h0001);
		wr_reg(cctc_pkg::A_STAT, 16'h0000);
		rd_reg(cctc_pkg::A_STAT, 16'h0000);
		`check_eq("irq cleared", 1'b0, irq_out)
		wr_reg(cctc_pkg::A_IOC0, 16'h0000);
		wr_reg(cctc_pkg::A_IEN, 16'h0000);
		wr_reg(cctc_pkg::A_CNT, 16'hfffe);
		wr_reg(cctc_pkg::A_CTRL, 16'h0001);
		repeat (2) @(posedge clk_in);
		wr_reg(cctc_pkg::A_CTRL, 16'h0000);
		rd_reg(cctc_pkg::A_CNT, 16'h0002);
		rd_reg(cctc_pkg::A_STAT, 16'h0014);
		`check_eq("wrap irq off", 1'b0, irq_out)
		wr_reg(cctc_pkg::A_IEN, 16'h0010);
		repeat (2) @(negedge clk_in);
		`check_eq("wrap irq on", 1'b1, irq_out)
		wr_reg(cctc_pkg::A_STAT, 16'h0000);
		wr_reg(cctc_pkg::A_IEN, 16'h0002);
		exp_b = 16'h1234;
		for (int m = 0; m < 3; m++)
		begin
			wr_reg(cctc_pkg::A_IOC0, {9'h000, 1'b1, 2'(m), 4'h0});
			for (int lv = 1; lv >= 0; lv--)
			begin
				wr_reg(cctc_pkg::A_CNT, 16'h0100 + 16'(m * 2 + lv));
				cctc_pin_model_inst.set_level(1, lv[0]);
				if ((lv == 1 && m != 1) || (lv == 0 && m != 0))
					exp_b = 16'h0100 + 16'(m * 2 + lv);
				rd_reg(4'h8, exp_b);
			end
		end
		`check_eq("capture irq", 1'b1, irq_out)
		wr_reg(cctc_pkg::A_MODE, 16'h0001);
		wr_reg(cctc_pkg::A_IOC0, 16'h0004);
		wr_reg(cctc_pkg::A_GRA, 16'h1111);
		wr_reg(cctc_pkg::A_CNT, 16'h0200);
		cctc_pin_model_inst.set_level(0, 1'b1);
		rd_reg(cctc_pkg::A_GRA, 16'h0200);
		rd_reg(4'h9, 16'h1111);
		cctc_pin_model_inst.set_level(0, 1'b0);
		wr_reg(cctc_pkg::A_IOC0, 16'h0000);
		wr_reg(4'h9, 16'h0003);
		wr_reg(cctc_pkg::A_GRA, 16'h0002);
		wr_reg(cctc_pkg::A_CNT, 16'h0000);
		wr_reg(cctc_pkg::A_CTRL, 16'h0001);
		repeat (3) @(posedge clk_in);
		wr_reg(cctc_pkg::A_CTRL, 16'h0000);
		rd_reg(cctc_pkg::A_GRA, 16'h0003);
		wr_reg(cctc_pkg::A_MODE, 16'h0000);
		for (int k = 0; k < 4; k++)
		begin
			wr_reg(cctc_pkg::A_CNT, 16'h0000);
			wr_reg(cctc_pkg::A_CTRL, 16'(k + 1));
			repeat (14) @(posedge clk_in);
			wr_reg(cctc_pkg::A_CTRL, 16'h0000);
			rd_reg(cctc_pkg::A_CNT, 16'h0010 >> k);
		end
		wr_reg(cctc_pkg::A_CNT, 16'h0000);
		wr_reg(cctc_pkg::A_CTRL, {13'h0000, cctc_pkg::CKS_EXT});
		cctc_pin_model_inst.ext_pulses(3);
		repeat (4) @(posedge clk_in);
		wr_reg(cctc_pkg::A_CTRL, 16'h0000);
		rd_reg(cctc_pkg::A_CNT, 16'h0003);
		wr_reg(cctc_pkg::A_IOC1, 16'h0020);
		wr_reg(cctc_pkg::A_GRD, 16'h0002);
		wr_reg(cctc_pkg::A_GRB, 16'h0001);
		wr_reg(cctc_pkg::A_STAT, 16'h0000);
		wr_reg(cctc_pkg::A_CNT, 16'h0000);
		wr_reg(cctc_pkg::A_CTRL, 16'h0001);
		@(posedge clk_in);
		clk_en_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		clk_en_in <= 1'b1;
		wr_reg(cctc_pkg::A_CTRL, 16'h0000);
		rd_reg(cctc_pkg::A_CNT, 16'h0003);
		@(negedge clk_in);
		`check_eq("read idle", 16'h0000, rd_data_out)
		`check_eq("pin d high", 1'b1, compare_out[3])
		rd_reg(cctc_pkg::A_STAT, 16'h000a);
		`check_eq("match b irq", 1'b1, irq_out)
		@(posedge clk_in);
		reset_in <= 1'b1;
		@(posedge clk_in);
		reset_in <= 1'b0;
		rd_reg(cctc_pkg::A_CNT, cctc_pkg::CNT_RESET);
		rd_reg(cctc_pkg::A_GRA, cctc_pkg::GR_RESET);
		results();
	end
endmodule : testbench
